//--- include/adcss_pkg.sv
// shared constants for the converter scan sequencer
package adcss_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   // register addresses
   localparam logic [19:0] CTRL_ADDR = 20'h89000;
   localparam logic [19:0] PMASK_ADDR = 20'h89004;
   localparam logic [19:0] AMASK_ADDR = 20'h89008;
   localparam logic [19:0] ADDC_ADDR = 20'h8900c;
   localparam logic [19:0] EXTC_ADDR = 20'h8900e;
   localparam logic [19:0] TRIG_ADDR = 20'h89010;
   localparam logic [19:0] EXIN_ADDR = 20'h89012;
   localparam logic [19:0] SMASK_ADDR = 20'h89014;
   // result window: base page, word index in addr[6:2]
   localparam logic [11:0] RES_PAGE = 12'h891;
   localparam logic [4:0] RES_COUNT = 5'h11;
   // control register fields
   localparam int CTL_DUP_LSB = 0;
   localparam int CTL_DOUBLE_TRIGGER_ENABLE = 7;
   localparam int CTL_EXTERNAL_TRIGGER_SELECT = 8;
   localparam int CTL_TRIGGER_ENABLE_BIT = 9;
   localparam int CTL_HSC = 10;
   localparam int CTL_MODE_LSB = 13;
   localparam int CTL_START = 15;
   // extended control, trigger select, extended input fields
   localparam int EXT_FMT = 15;
   localparam int TRG_B_LSB = 0;
   localparam int TRG_A_LSB = 8;
   localparam int EXIN_TSAD = 0;
   localparam int EXIN_OCAD = 1;
   localparam int EXIN_TSS = 8;
   localparam int EXIN_OCS = 9;
   // writable channel bits: 5 and 7 reserved
   localparam logic [15:0] CH_VALID = 16'hff5f;
   localparam logic [15:0] RESET_MASK = 16'h0000;
   localparam logic [3:0] TRIG_PIN_SEL = 4'h0;
   // channel codes toward the analog core
   localparam logic [4:0] CH_TEMP = 5'h10;
   localparam logic [4:0] CH_VREF = 5'h11;
   localparam logic [4:0] INT_RES_IDX = 5'h10;
   // trigger pin least low time, tenths of a clock, and whole cycles
   localparam int TRIG_LOW_MIN_X10 = 15;
   localparam int TRIG_LOW_MIN_CYC = (TRIG_LOW_MIN_X10 + 9) / 10;
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_GROUP = 2'b01,
      MODE_CONT = 2'b10,
      MODE_BAD = 2'b11
   } adcss_mode_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT = 2'b10,
      ST_STORE = 2'b11
   } adcss_state_t;
endpackage : adcss_pkg

//--- hdl/adcss_pin_sync.sv
// trigger pin synchroniser and falling edge detector
`timescale 1ns/10ps
module adcss_pin_sync
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_pin_n,
   output logic o_fall
);
   import adcss_pkg::*;
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic low_cnt_q;

   // level starts high, so a pin held low through reset gives an edge after release
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end
      else
      begin
         s1_q <= i_pin_n;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts only once the second and third stage agree
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         level_q <= 1'b1;
      else if (s2_q == s3_q)
         level_q <= s3_q;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         o_fall <= 1'b0;
      else
         o_fall <= level_q && (s2_q == s3_q) && !s3_q;
   end

   // helper: the pin was seen low for the least time before the edge
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         low_cnt_q <= 1'b0;
      else
         low_cnt_q <= !s2_q && !s3_q;
   end

   pin_low_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_fall |-> $past(!s3_q, TRIG_LOW_MIN_CYC - 1) && low_cnt_q)
      else $error("trigger edge accepted without low pin");
endmodule : adcss_pin_sync

//--- hdl/adcss_result_mem.sv
// result store with a registered read port and register bypass
`timescale 1ns/10ps
module adcss_result_mem
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_we,
   input wire logic [4:0] i_waddr,
   input wire logic [15:0] i_wdata,
   input wire logic i_re,
   input wire logic [4:0] i_raddr,
   input wire logic i_alt_sel,
   input wire logic [15:0] i_alt_data,
   output logic [15:0] o_rdata
);
   logic [15:0] mem_q [0:31];

   // no reset on the array; results are undefined until converted
   always_ff @(posedge i_clock)
   begin
      if (i_we)
         mem_q[i_waddr] <= i_wdata;
   end

   // read data stand for exactly one cycle after the strobe
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         o_rdata <= 16'h0000;
      else if (!i_re)
         o_rdata <= 16'h0000;
      else if (i_alt_sel)
         o_rdata <= i_alt_data;
      else
         o_rdata <= mem_q[i_raddr];
   end
endmodule : adcss_result_mem

//--- hdl/adcss_seq.sv
// scan sequencer: registers, trigger start logic and channel walk
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
//
// Contract
// - single scan: enabled primary channels once, ascending
// - continuous scan: repeat ascending passes until stopped
// - group A trigger: one primary pass, stop
// - group B trigger: one secondary pass, stop
// - internal source: single mode, empty mask, stop
// - software write of one sets start
// - enabled group A timer trigger sets start
// - group B trigger in group mode sets start
// - enabled pin trigger with select zero sets start
// - software write of zero clears start
// - single scan end or internal end clears start
// - either group pass end clears start
// - mask bit n enables channel n; 5,7 zero
// - double trigger uses duplication channel as group A
// - secondary mask used only in group mode
// - addition channels converted count times, summed
// - other channels converted once, stored
// - non-addition result aligned by format bit
// - mode field: single, group, continuous, prohibited
// - addition count field gives one to four
// - addition results always left-aligned
// - pin falling edge starts; pin held low
module adcss_seq
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [adcss_pkg::ADDR_W-1:0] i_addr,
   input wire logic [adcss_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [adcss_pkg::DATA_W-1:0] o_rdata,
   input wire logic [15:0] i_sync_trig,
   input wire logic i_ext_trig_n,
   input wire logic i_conv_done,
   input wire logic [11:0] i_conv_data,
   output logic o_conv_req,
   output logic [4:0] o_conv_chan,
   output logic o_high_speed,
   output logic o_scanning
);
   import adcss_pkg::*;

   // lowest enabled channel of a mask
   function automatic logic [3:0] lowest_ch(input logic [15:0] m);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--)
         if (m[i])
            r = 4'(i);
      return r;
   endfunction : lowest_ch

   logic [4:0] dup_q;
   logic double_trigger_enable_q;
   logic external_trigger_select_q;
   logic trigger_enable_bit_q;
   logic hsc_q;
   adcss_mode_t mode_q;
   logic start_q;
   logic [15:0] pmask_q;
   logic [15:0] amask_q;
   logic [15:0] smask_q;
   logic [1:0] addc_q;
   logic fmt_q;
   logic [3:0] trs_a_q;
   logic [3:0] trs_b_q;
   logic [3:0] exin_q;
   logic grp_b_q;
   adcss_state_t state_q;
   logic [15:0] pend_q;
   logic [4:0] cur_q;
   logic int_q;
   logic [13:0] acc_q;
   logic [2:0] reps_q;
   logic wr_ctrl;
   logic sw_set;
   logic sw_clr;
   logic pin_fall;
   logic trig_a;
   logic trig_b;
   logic trig_pin;
   logic set_evt;
   logic [15:0] load_mask;
   logic int_sel;
   logic add_on;
   logic [2:0] target;
   logic [15:0] pend_left;
   logic pass_end;
   logic mem_we;
   logic [15:0] result;
   logic res_hit;
   logic [15:0] reg_rdata;
   adcss_pin_sync u_pin
   (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_pin_n(i_ext_trig_n),
      .o_fall(pin_fall)
   );
   assign wr_ctrl = i_wr && (i_addr == CTRL_ADDR);
   assign sw_set = wr_ctrl && i_wdata[CTL_START];
   assign sw_clr = wr_ctrl && !i_wdata[CTL_START];
   assign trig_a = trigger_enable_bit_q && !external_trigger_select_q && (trs_a_q != TRIG_PIN_SEL)
      && i_sync_trig[trs_a_q];
   assign trig_b = (mode_q == MODE_GROUP) && trigger_enable_bit_q && (trs_b_q != TRIG_PIN_SEL)
      && i_sync_trig[trs_b_q];
   assign trig_pin = trigger_enable_bit_q && external_trigger_select_q && (trs_a_q == TRIG_PIN_SEL) && pin_fall;
   assign set_evt = sw_set || trig_a || trig_b || trig_pin;

   // group B set on a group B pass, else duplication channel in double trigger mode, else group A set
   assign load_mask = (grp_b_q && mode_q == MODE_GROUP) ? smask_q
      : double_trigger_enable_q ? (16'h0001 << dup_q[3:0]) & CH_VALID
      : pmask_q;
   assign int_sel = (mode_q == MODE_SINGLE) && (exin_q[2] || exin_q[3]);
   assign add_on = int_q ? (cur_q == CH_TEMP ? exin_q[0] : exin_q[1])
      : amask_q[cur_q[3:0]];
   assign target = add_on ? 3'({1'b0, addc_q} + 3'h1) : 3'h1;
   assign pend_left = pend_q & ~(16'h0001 << cur_q[3:0]);
   assign pass_end = (state_q == ST_STORE) && (int_q || pend_left == 16'h0000)
      && (mode_q != MODE_CONT);
   assign mem_we = (state_q == ST_STORE);
   always_comb
   begin
      if (add_on)
         result = {acc_q, 2'b00};
      else if (fmt_q)
         result = {acc_q[11:0], 4'h0};
      else
         result = {4'h0, acc_q[11:0]};
   end
   // control register and start bit; a set wins over any clear
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         start_q <= 1'b0;
      else if (set_evt)
         start_q <= 1'b1;
      else if (sw_clr || pass_end)
         start_q <= 1'b0;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         dup_q <= 5'h00;
         double_trigger_enable_q <= 1'b0;
         external_trigger_select_q <= 1'b0;
         trigger_enable_bit_q <= 1'b0;
         hsc_q <= 1'b0;
         mode_q <= MODE_SINGLE;
      end
      else if (wr_ctrl)
      begin
         dup_q <= i_wdata[CTL_DUP_LSB +: 5];
         double_trigger_enable_q <= i_wdata[CTL_DOUBLE_TRIGGER_ENABLE];
         external_trigger_select_q <= i_wdata[CTL_EXTERNAL_TRIGGER_SELECT];
         trigger_enable_bit_q <= i_wdata[CTL_TRIGGER_ENABLE_BIT];
         hsc_q <= i_wdata[CTL_HSC];
         mode_q <= adcss_mode_t'(i_wdata[CTL_MODE_LSB +: 2]);
      end
   end
   // mask and option registers; software keeps them still while running
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         pmask_q <= RESET_MASK;
         amask_q <= RESET_MASK;
         smask_q <= RESET_MASK;
         addc_q <= 2'b00;
         fmt_q <= 1'b0;
         trs_a_q <= 4'h0;
         trs_b_q <= 4'h0;
         exin_q <= 4'h0;
      end
      else if (i_wr)
      begin
         case (i_addr)
            PMASK_ADDR: pmask_q <= i_wdata & CH_VALID;
            AMASK_ADDR: amask_q <= i_wdata & CH_VALID;
            SMASK_ADDR: smask_q <= i_wdata & CH_VALID;
            ADDC_ADDR: addc_q <= i_wdata[1:0];
            EXTC_ADDR: fmt_q <= i_wdata[EXT_FMT];
            TRIG_ADDR:
            begin
               trs_a_q <= i_wdata[TRG_A_LSB +: 4];
               trs_b_q <= i_wdata[TRG_B_LSB +: 4];
            end
            EXIN_ADDR: exin_q <= {i_wdata[EXIN_OCS], i_wdata[EXIN_TSS],
               i_wdata[EXIN_OCAD], i_wdata[EXIN_TSAD]};
            default: ;
         endcase
      end
   end
   // which group the next pass walks; only a lone group B trigger picks B
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         grp_b_q <= 1'b0;
      else if (!start_q && set_evt)
         grp_b_q <= trig_b && !(sw_set || trig_a || trig_pin);
   end
   // channel walk
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         state_q <= ST_IDLE;
         pend_q <= 16'h0000;
         cur_q <= 5'h00;
         int_q <= 1'b0;
         acc_q <= 14'h0000;
         reps_q <= 3'h0;
      end
      else if (sw_clr && !set_evt)
         state_q <= ST_IDLE;
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               acc_q <= 14'h0000;
               reps_q <= 3'h0;
               if (start_q)
               begin
                  pend_q <= load_mask;
                  int_q <= (load_mask == 16'h0000) && int_sel;
                  cur_q <= (load_mask == 16'h0000)
                     ? (exin_q[2] ? CH_TEMP : CH_VREF)
                     : {1'b0, lowest_ch(load_mask)};
                  if (load_mask != 16'h0000 || int_sel)
                     state_q <= ST_ISSUE;
                  else
                     state_q <= ST_STORE;
               end
            end
            ST_ISSUE:
               state_q <= ST_WAIT;
            ST_WAIT:
            begin
               if (i_conv_done)
               begin
                  acc_q <= acc_q + {2'b00, i_conv_data};
                  reps_q <= reps_q + 3'h1;
                  if (reps_q + 3'h1 >= target)
                     state_q <= ST_STORE;
                  else
                     state_q <= ST_ISSUE;
               end
            end
            ST_STORE:
            begin
               acc_q <= 14'h0000;
               reps_q <= 3'h0;
               if (!int_q && pend_left != 16'h0000)
               begin
                  pend_q <= pend_left;
                  cur_q <= {1'b0, lowest_ch(pend_left)};
                  state_q <= ST_ISSUE;
               end
               else if (mode_q == MODE_CONT && load_mask != 16'h0000)
               begin
                  pend_q <= load_mask;
                  cur_q <= {1'b0, lowest_ch(load_mask)};
                  state_q <= ST_ISSUE;
               end
               else
                  state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end
   // registered outputs: requests to the analog core and status levels
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         o_conv_req <= 1'b0;
         o_conv_chan <= 5'h00;
         o_high_speed <= 1'b0;
         o_scanning <= 1'b0;
      end
      else
      begin
         o_conv_req <= (state_q == ST_ISSUE) && !(sw_clr && !set_evt);
         o_conv_chan <= cur_q;
         o_high_speed <= hsc_q;
         o_scanning <= start_q;
      end
   end
   // register read path
   assign res_hit = (i_addr[19:8] == RES_PAGE) && (i_addr[6:2] < RES_COUNT)
      && (i_addr[7] == 1'b0) && (i_addr[1:0] == 2'b00);
   always_comb
   begin
      case (i_addr)
         CTRL_ADDR: reg_rdata = {start_q, mode_q, 2'b00, hsc_q, trigger_enable_bit_q, external_trigger_select_q,
            double_trigger_enable_q, 2'b00, dup_q};
         PMASK_ADDR: reg_rdata = pmask_q;
         AMASK_ADDR: reg_rdata = amask_q;
         SMASK_ADDR: reg_rdata = smask_q;
         ADDC_ADDR: reg_rdata = {14'h0000, addc_q};
         EXTC_ADDR: reg_rdata = {fmt_q, 15'h0000};
         TRIG_ADDR: reg_rdata = {4'h0, trs_a_q, 4'h0, trs_b_q};
         EXIN_ADDR: reg_rdata = {6'h00, exin_q[3:2], 6'h00, exin_q[1:0]};
         default: reg_rdata = 16'h0000;
      endcase
   end

   adcss_result_mem u_mem
   (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_we(mem_we && (int_q || load_mask != 16'h0000 || pend_q != 16'h0000)),
      .i_waddr(int_q ? INT_RES_IDX : {1'b0, cur_q[3:0]}),
      .i_wdata(result),
      .i_re(i_rd),
      .i_raddr(i_addr[6:2]),
      .i_alt_sel(!res_hit),
      .i_alt_data(reg_rdata),
      .o_rdata(o_rdata)
   );
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   sw_start_a: assert property (sw_set |=> start_q)
      else $error("software start write did not set start");
   sw_stop_a: assert property (sw_clr && !set_evt |=> !start_q && state_q == ST_IDLE)
      else $error("software stop did not stop the scan");
   trig_a_a: assert property (trig_a |=> start_q)
      else $error("group A trigger did not set start");
   trig_b_a: assert property (trig_b && !start_q |=> start_q && (grp_b_q
      || $past(sw_set || trig_a || trig_pin)))
      else $error("group B trigger did not start group B");
   pin_trig_a: assert property (trig_pin |=> start_q)
      else $error("pin trigger did not set start");
   single_end_a: assert property (pass_end && !set_evt && mode_q == MODE_SINGLE
      |=> !start_q ##1 state_q == ST_IDLE)
      else $error("single scan end did not clear start");
   group_end_a: assert property (pass_end && !set_evt && mode_q == MODE_GROUP
      |=> !start_q)
      else $error("group pass end did not clear start");
   cont_wrap_a: assert property (state_q == ST_STORE && mode_q == MODE_CONT
      && pend_left == 16'h0000 && load_mask != 16'h0000 && !sw_clr
      |=> state_q == ST_ISSUE && pend_q == $past(load_mask) && start_q)
      else $error("continuous scan did not restart from lowest");
   ascend_a: assert property (state_q == ST_ISSUE && !int_q
      |-> pend_q[cur_q[3:0]] && (pend_q & ((16'h0001 << cur_q[3:0]) - 16'h0001))
      == 16'h0000)
      else $error("channel walk not in ascending order");
   add_count_a: assert property (state_q == ST_WAIT && i_conv_done && !sw_clr
      && reps_q + 3'h1 < target
      |=> state_q == ST_ISSUE ##1 (o_conv_req || $past(sw_clr)))
      else $error("addition channel not reconverted");
   align_a: assert property (mem_we && !add_on && reps_q != 3'h0
      |-> reps_q == 3'h1 && (fmt_q ? result[3:0] == 4'h0 : result[15:12] == 4'h0))
      else $error("right aligned result has high bits set");
endmodule : adcss_seq

//--- tb/adcss_core_model.sv
// behavioural analog core answering each conversion request after a delay
`timescale 1ns/10ps
module adcss_core_model
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_conv_req,
   input wire logic [4:0] i_conv_chan,
   input wire logic [2:0] i_delay,
   output logic o_conv_done,
   output logic [11:0] o_conv_data
);
   logic busy_q;
   logic [2:0] cnt_q;
   logic [4:0] chan_q;
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         busy_q <= 1'b0;
         cnt_q <= 3'h0;
         chan_q <= 5'h00;
         o_conv_done <= 1'b0;
         o_conv_data <= 12'h000;
      end
      else
      begin
         o_conv_done <= 1'b0;
         // data toggles outside done so a late sample shows garbage
         o_conv_data <= ~o_conv_data;
         if (i_conv_req)
         begin
            busy_q <= 1'b1;
            cnt_q <= i_delay;
            chan_q <= i_conv_chan;
         end
         else if (busy_q && cnt_q <= 3'h1)
         begin
            busy_q <= 1'b0;
            o_conv_done <= 1'b1;
            o_conv_data <= {3'h5, chan_q, 4'h3};
         end
         else if (busy_q)
            cnt_q <= cnt_q - 3'h1;
      end
   end
endmodule : adcss_core_model

//--- tb/adcss_seq_tb.sv
// self-checking bench for the scan sequencer
`timescale 1ns/10ps
module adcss_seq_tb;
   import adcss_pkg::*;
   logic i_clock;
   logic i_sys_rst;
   logic [19:0] i_addr;
   logic [15:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic [15:0] o_rdata;
   logic [15:0] i_sync_trig;
   logic i_ext_trig_n;
   logic i_conv_done;
   logic [11:0] i_conv_data;
   logic o_conv_req;
   logic [4:0] o_conv_chan;
   logic o_high_speed;
   logic o_scanning;
   logic [2:0] delay;
   logic rd_d = 1'b0;
   logic [15:0] exp_rd[$];
   logic [4:0] exp_ch[$];
   int err_total = 0;
   int check_count = 0;
   int unsigned seed_v;
   logic [15:0] mask;
   logic [13:0] sum;

   adcss_seq dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_sync_trig(i_sync_trig), .i_ext_trig_n(i_ext_trig_n), .i_conv_done(i_conv_done),
      .i_conv_data(i_conv_data), .o_conv_req(o_conv_req), .o_conv_chan(o_conv_chan),
      .o_high_speed(o_high_speed), .o_scanning(o_scanning));
   adcss_core_model core (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_conv_req(o_conv_req),
      .i_conv_chan(o_conv_chan), .i_delay(delay), .o_conv_done(i_conv_done),
      .o_conv_data(i_conv_data));

   initial
   begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
         err_total++;
      end
   endtask : chk

   // oldest note is taken off whenever read data or a conversion request appears
   always @(posedge i_clock)
   begin
      if (rd_d)
         chk("read data", exp_rd.pop_front(), o_rdata);
      if (!i_sys_rst && o_conv_req)
      begin
         if (exp_ch.size() == 0)
            chk("request count", 16'h0000, 16'h0001);
         else
            chk("request channel", {11'h0, exp_ch.pop_front()}, {11'h0, o_conv_chan});
      end
      rd_d <= i_rd;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [19:0] a, input logic [15:0] e);
      exp_rd.push_back(e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
   endtask : rd

   task automatic trig(input int k);
      @(posedge i_clock);
      i_sync_trig <= 16'h0001 << k;
      @(posedge i_clock);
      i_sync_trig <= 16'h0000;
   endtask : trig

   // bounded wait for all expected requests, and optionally the stop
   task automatic wait_done(input bit idle);
      int n;
      n = 0;
      repeat (3) @(posedge i_clock);
      while ((exp_ch.size() != 0 || (idle && o_scanning !== 1'b0)) && n < 3000)
      begin
         @(posedge i_clock);
         n++;
      end
      if (n == 3000)
      begin
         $display("CHECK FAILED scan wait expected done seen hang");
         err_total++;
         end_sim();
      end
      else if (idle)
         repeat (8) @(posedge i_clock);
   endtask : wait_done

   initial
   begin
      i_sys_rst = 1'b1;
      i_addr = 20'h00000;
      i_wdata = 16'h0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_sync_trig = 16'h0000;
      i_ext_trig_n = 1'b1;
      delay = 3'h1;
      seed_v = $urandom(32'h14a1);
      repeat (10) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      rd(CTRL_ADDR, 16'h0000);
      rd(PMASK_ADDR, 16'h0000);
      rd(20'h89020, 16'h0000);
      wr(PMASK_ADDR, 16'hffff);
      wr(AMASK_ADDR, 16'hffff);
      wr(SMASK_ADDR, 16'hffff);
      rd(PMASK_ADDR, 16'hff5f);
      rd(AMASK_ADDR, 16'hff5f);
      rd(SMASK_ADDR, 16'hff5f);
      wr(AMASK_ADDR, 16'h0000);
      // random primary mask, full secondary mask must be ignored
      mask = 16'($urandom()) & 16'hff5f;
      if (mask == 16'h0000)
         mask = 16'h0001;
      delay = 3'($urandom_range(4, 1));
      wr(PMASK_ADDR, mask);
      for (int n = 0; n < 16; n++)
         if (mask[n])
            exp_ch.push_back(5'(n));
      wr(CTRL_ADDR, 16'h8000);
      wait_done(1'b1);
      rd(CTRL_ADDR, 16'h0000);
      // every addition count, format toggled each pass
      wr(PMASK_ADDR, 16'h000c);
      wr(AMASK_ADDR, 16'h0004);
      for (int c = 0; c < 4; c++)
      begin
         wr(ADDC_ADDR, 16'(c));
         wr(EXTC_ADDR, {c[0], 15'h0000});
         repeat (c + 1)
            exp_ch.push_back(5'h02);
         exp_ch.push_back(5'h03);
         wr(CTRL_ADDR, 16'h8000);
         wait_done(1'b1);
         sum = 14'(c + 1) * 14'ha23;
         rd(20'h89108, {sum, 2'b00});
         rd(20'h8910c, c[0] ? 16'ha330 : 16'h0a33);
      end
      // continuous passes, stop mid-scan, restart from lowest
      wr(AMASK_ADDR, 16'h0000);
      wr(PMASK_ADDR, 16'h0101);
      delay = 3'h6;
      wr(CTRL_ADDR, 16'h4000);
      for (int k = 0; k < 5; k++)
         exp_ch.push_back(k[0] ? 5'h08 : 5'h00);
      wr(CTRL_ADDR, 16'hc000);
      wait_done(1'b0);
      wr(CTRL_ADDR, 16'h4000);
      repeat (30) @(posedge i_clock);
      rd(CTRL_ADDR, 16'h4000);
      wr(CTRL_ADDR, 16'h0000);
      exp_ch.push_back(5'h00);
      exp_ch.push_back(5'h08);
      wr(CTRL_ADDR, 16'h8000);
      wait_done(1'b1);
      // group scan, distinct triggers and channels per group
      delay = 3'h2;
      wr(CTRL_ADDR, 16'h2200);
      wr(TRIG_ADDR, 16'h0102);
      wr(PMASK_ADDR, 16'h0003);
      wr(SMASK_ADDR, 16'h0300);
      exp_ch.push_back(5'h00);
      exp_ch.push_back(5'h01);
      trig(1);
      wait_done(1'b1);
      exp_ch.push_back(5'h08);
      exp_ch.push_back(5'h09);
      trig(2);
      wait_done(1'b1);
      rd(CTRL_ADDR, 16'h2200);
      // triggers that must not start a scan
      wr(CTRL_ADDR, 16'h0600);
      trig(2);
      trig(3);
      chk("high speed", 16'h0001, {15'h0000, o_high_speed});
      wr(CTRL_ADDR, 16'h0000);
      trig(1);
      repeat (20) @(posedge i_clock);
      chk("scanning", 16'h0000, {15'h0000, o_scanning});
      chk("high speed", 16'h0000, {15'h0000, o_high_speed});
      // double trigger replaces the primary mask
      wr(CTRL_ADDR, 16'h0289);
      exp_ch.push_back(5'h09);
      trig(1);
      wait_done(1'b1);
      // pin trigger, held low two cycles
      wr(CTRL_ADDR, 16'h0000);
      wr(TRIG_ADDR, 16'h0002);
      wr(PMASK_ADDR, 16'h0010);
      wr(CTRL_ADDR, 16'h0300);
      exp_ch.push_back(5'h04);
      @(posedge i_clock);
      i_ext_trig_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_ext_trig_n <= 1'b1;
      wait_done(1'b1);
      // internal source needs single mode and an empty mask
      wr(CTRL_ADDR, 16'h0000);
      wr(PMASK_ADDR, 16'h0000);
      wr(EXIN_ADDR, 16'h0100);
      exp_ch.push_back(5'h10);
      wr(CTRL_ADDR, 16'h8000);
      wait_done(1'b1);
      rd(20'h89140, 16'hb030);
      repeat (2) @(posedge i_clock);
      end_sim();
   end
endmodule : adcss_seq_tb
